// ==== bench/far_side_model.sv ====
// Purpose: Behavioural motor that reports arrival at its reference.
// Assumes: Reference settles after a fixed number of cycles.
// Notes: Zero reference never counts as reached, like a stalled shaft.
`default_nettype none
module far_side_model (
    input wire logic clk_i,
    input wire logic [seq_pkg::PCT_W-1:0] reference_i,
    output var logic on_reference_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [seq_pkg::PCT_W-1:0] last_q = '0;
    int settle_q = 0;
    initial on_reference_o = 1'b0;
    // Any reference change restarts the settling count
    always @(posedge clk_i) begin
        last_q <= reference_i;
        settle_q <= (reference_i != last_q) ? 0 : settle_q + 1;
        on_reference_o <= (settle_q >= 12) && (reference_i != 0);
    end
endmodule
`default_nettype wire

// ==== bench/seq_chk.sv ====
// Purpose: Port-level temporal checks of the event/action sequencer.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Scan strobe is internal, so pulses are judged by their effects.
`default_nettype none
module seq_chk #(
    parameter int NUM_PAIRS = 20
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [seq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic stop_cmd_i,
    input wire logic [seq_pkg::PCT_W-1:0] active_reference_o,
    input wire logic ramp_down_o,
    input wire logic [seq_pkg::IDX_W-1:0] current_pair_o,
    input wire logic action_pulse_o,
    input wire logic [seq_pkg::CODE_W-1:0] action_code_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import seq_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Every access costs exactly one wait state
    wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("access wait state wrong");
    // Holes in the map read back as zero
    hole_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == 8'h20 |-> avs_readdata_o == UNMAPPED_DATA)
        else $error("unmapped read not zero");
    pulse_single_a: assert property (
        action_pulse_o |=> !action_pulse_o)
        else $error("action pulse longer than one cycle");
    pair_range_a: assert property (
        current_pair_o >= 1 && current_pair_o <= NUM_PAIRS)
        else $error("pair index out of range");
    pair_step_a: assert property ($changed(current_pair_o) |->
        current_pair_o == 1 || current_pair_o == $past(current_pair_o) + 5'h01)
        else $error("pair index jumped");
    code_pulse_a: assert property (
        $changed(action_code_o) |-> action_pulse_o)
        else $error("action code changed without pulse");
    ramp_zero_a: assert property (
        ramp_down_o |-> active_reference_o == 0)
        else $error("reference not zero while stopped");
    stop_ramp_a: assert property (
        $rose(stop_cmd_i) |-> ##[1:4] ramp_down_o)
        else $error("stop did not ramp down");
endmodule
bind event_action_sequencer seq_chk #(.NUM_PAIRS(NUM_PAIRS)) chk (
    .clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .stop_cmd_i, .active_reference_o,
    .ramp_down_o, .current_pair_o, .action_pulse_o, .action_code_o);
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the event/action sequencer.
// Assumes: Scan every 4 cycles, timer tick every 2 cycles.
// Notes: Expected action codes are queued ahead and popped per pulse.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import seq_pkg::*;
    logic clk = 0, sys_rst = 1, rd = 0, wr = 0, stop = 0;
    logic wreq, ramp, pulse, on_ref;
    logic [7:0] addr = '0, code, e;
    logic [31:0] wdata = '0, rdata, d, seed = 32'h2876;
    logic [3:0] be = 4'hF;
    logic [6:0] ref_pct, p0, p1;
    logic [4:0] pair;
    logic [7:0] exp_q[$];
    int fails = 0, comparisons = 0, seen = 0;
    time t0 = 0;
    event_action_sequencer #(.SCAN_CYCLES(4), .TICK_CYCLES(2)) uut (
        .clk_i(clk), .sys_rst_i(sys_rst), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .on_reference_i(on_ref),
        .stop_cmd_i(stop), .active_reference_o(ref_pct),
        .ramp_down_o(ramp), .current_pair_o(pair),
        .action_pulse_o(pulse), .action_code_o(code));
    far_side_model motor (.clk_i(clk), .reference_i(ref_pct),
        .on_reference_o(on_ref));
    // Free-running 10 MHz clock
    always #50 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Held until the rising edge that samples waitrequest low; data taken there
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= v;
        do @(posedge clk); while (wreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Bounded wait for a number of executed actions
    task automatic wait_seen(input int n);
        for (int i = 0; i < 2000 && seen < n; i++) @(negedge clk);
        check(seen, n);
    endtask
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Every action pulse must match the oldest queued expectation
    always @(negedge clk) begin
        if (pulse === 1'b1) begin
            seen++;
            e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
            check(code, e);
            if (e === AC_TIMER0) begin
                t0 = $time;
                check(ref_pct, p0);
            end
            // Six ticks of two cycles, then at most one more scan interval
            if (e === AC_PRESET1) begin
                check(32'(($time - t0) inside {[1200:1600]}), 1);
            end
        end
    end
    // Hang guard, well beyond the expected run length
    initial begin
        #1000000;
        fails++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(pair, 5'h01);
        check(code, AC_NONE);
        bus(0, REG_CTRL, 0);
        check(d, 32'h0);
        bus(0, 8'h20, 0);
        check(d, UNMAPPED_DATA);
        p0 = 7'(rnd() % 100 + 1);
        p1 = 7'(rnd() % 100);
        bus(1, REG_PRESET0, p0);
        bus(1, REG_PRESET1, p1);
        bus(1, REG_TIMER, 6);
        bus(1, REG_PAIR_BASE, {AC_PRESET0, EV_FALSE});
        bus(1, REG_PAIR_BASE + 8'h04, {AC_TIMER0, EV_ON_REF});
        bus(1, REG_PAIR_BASE + 8'h08, {AC_PRESET1, EV_TIMEOUT0});
        bus(0, REG_PAIR_BASE + 8'h04, 0);
        check(d, {16'h0, AC_TIMER0, EV_ON_REF});
        // Always-false first event: any pulse here hits an empty queue
        bus(1, REG_CTRL, 32'h0301);
        repeat (40) @(posedge clk);
        exp_q = {AC_PRESET0, AC_TIMER0, AC_PRESET1, AC_PRESET0, AC_TIMER0};
        bus(1, REG_PAIR_BASE, {AC_PRESET0, EV_TRUE});
        wait_seen(5);
        // Switch off while timer zero is still counting
        bus(1, REG_CTRL, 32'h0300);
        bus(0, REG_STATUS, 0);
        check(d & 32'h0000_071F, 32'h0);
        check(pair, 5'h01);
        exp_q = {AC_PRESET0, AC_TIMER0};
        bus(1, REG_CTRL, 32'h0301);
        wait_seen(7);
        @(posedge clk);
        stop <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(ramp, 1'b1);
        check(ref_pct, 7'h00);
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== src/event_action_sequencer.sv ====
// Purpose: Event/action sequencer with timer zero and two preset speeds.
// Assumes: Avalon-MM slave, one wait state on every access.
// Notes: Scan interval and timer tick are one-cycle enables from dividers.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`default_nettype none
module event_action_sequencer
    import seq_pkg::*;
#(
    parameter int NUM_PAIRS = seq_pkg::MAX_PAIRS,
    parameter int SCAN_CYCLES = seq_pkg::SCAN_CYC,
    parameter int TICK_CYCLES = seq_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [seq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic on_reference_i,
    input wire logic stop_cmd_i,
    output logic [seq_pkg::PCT_W-1:0] active_reference_o,
    output logic ramp_down_o,
    output logic [seq_pkg::IDX_W-1:0] current_pair_o,
    output logic action_pulse_o,
    output logic [seq_pkg::CODE_W-1:0] action_code_o
);
    import seq_pkg::*;
    // Refuse sizes that the table index or the dividers cannot serve
    if (NUM_PAIRS < 1 || NUM_PAIRS > MAX_PAIRS || SCAN_CYCLES < 2 ||
        TICK_CYCLES < 1) begin : g_bad_param
        $error("event_action_sequencer parameters out of range");
    end
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_STOP = 2'b10
    } seq_state_t;
    // Pin inputs pass two flops before use
    logic [1:0] ref_sync_q, ref_sync_d;
    logic [1:0] stop_sync_q, stop_sync_d;
    logic at_ref, stop_req;
    always_comb begin
        ref_sync_d = {ref_sync_q[0], on_reference_i};
        stop_sync_d = {stop_sync_q[0], stop_cmd_i};
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_sync_q <= 2'b00;
            stop_sync_q <= 2'b00;
        end else begin
            ref_sync_q <= ref_sync_d;
            stop_sync_q <= stop_sync_d;
        end
    end
    assign at_ref = ref_sync_q[1];
    assign stop_req = stop_sync_q[1];
    // Scan strobe and timer tick dividers
    logic [31:0] scan_cnt_q, scan_cnt_d, tick_cnt_q, tick_cnt_d;
    logic scan_q, scan_d, tick_q, tick_d;
    always_comb begin
        scan_d = 1'b0;
        tick_d = 1'b0;
        scan_cnt_d = scan_cnt_q + 32'h0000_0001;
        tick_cnt_d = tick_cnt_q + 32'h0000_0001;
        if (scan_cnt_q == 32'(SCAN_CYCLES - 1)) begin
            scan_cnt_d = 32'h0000_0000;
            scan_d = 1'b1;
        end
        if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scan_cnt_q <= 32'h0000_0000;
            tick_cnt_q <= 32'h0000_0000;
            scan_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            scan_cnt_q <= scan_cnt_d;
            tick_cnt_q <= tick_cnt_d;
            scan_q <= scan_d;
            tick_q <= tick_d;
        end
    end
    // Programmable registers and pair tables
    logic on_q, on_d;
    logic [IDX_W-1:0] count_q, count_d;
    logic [TMR_W-1:0] tpreset_q, tpreset_d;
    logic [PCT_W-1:0] preset0_q, preset0_d, preset1_q, preset1_d;
    logic [CODE_W-1:0] ev_q [NUM_PAIRS], ev_d [NUM_PAIRS];
    logic [CODE_W-1:0] ac_q [NUM_PAIRS], ac_d [NUM_PAIRS];
    logic ack_q, ack_d, wr_go, rd_go;
    logic [31:0] rdata_q, rdata_d;
    // Sequencer state
    seq_state_t state_q, state_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic trun_q, trun_d, texp_q, texp_d, sel_q, sel_d, act_q, act_d, ev_hit;
    logic [CODE_W-1:0] acode_q, acode_d, cur_ev, cur_ac;
    // One wait state; a write lands only at the edge that sees waitrequest low
    assign wr_go = avs_write_i && ack_q;
    assign rd_go = avs_read_i && !ack_q;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign avs_readdata_o = rdata_q;
    // Pair table per entry: low byte event, next byte action
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
            always_comb begin
                ev_d[g] = ev_q[g];
                ac_d[g] = ac_q[g];
                if (wr_go && avs_address_i ==
                    ADDR_W'(REG_PAIR_BASE + ADDR_W'(4 * g))) begin
                    if (avs_byteenable_i[0]) begin
                        ev_d[g] = avs_writedata_i[CODE_W-1:0];
                    end
                    if (avs_byteenable_i[1]) begin
                        ac_d[g] = avs_writedata_i[PAIR_ACT_LSB +: CODE_W];
                    end
                end
            end
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    ev_q[g] <= EV_FALSE;
                    ac_q[g] <= AC_NONE;
                end else begin
                    ev_q[g] <= ev_d[g];
                    ac_q[g] <= ac_d[g];
                end
            end
        end
    endgenerate
    // Register writes and read mux
    always_comb begin
        on_d = on_q;
        count_d = count_q;
        tpreset_d = tpreset_q;
        preset0_d = preset0_q;
        preset1_d = preset1_q;
        ack_d = (avs_read_i || avs_write_i) && !ack_q;
        rdata_d = rdata_q;
        if (wr_go && avs_byteenable_i[0]) begin
            case (avs_address_i)
                REG_CTRL: on_d = avs_writedata_i[CTRL_ON_BIT];
                REG_PRESET0: preset0_d = avs_writedata_i[PCT_W-1:0];
                REG_PRESET1: preset1_d = avs_writedata_i[PCT_W-1:0];
                default: ;
            endcase
        end
        if (wr_go && avs_address_i == REG_CTRL && avs_byteenable_i[1]) begin
            count_d = avs_writedata_i[CTRL_CNT_LSB +: IDX_W];
            if (count_d > IDX_W'(NUM_PAIRS)) begin
                count_d = IDX_W'(NUM_PAIRS);
            end
        end
        if (wr_go && avs_address_i == REG_TIMER) begin
            tpreset_d = avs_writedata_i[TMR_W-1:0];
        end
        if (rd_go) begin
            rdata_d = UNMAPPED_DATA;
            case (avs_address_i)
                REG_CTRL: begin
                    rdata_d[CTRL_ON_BIT] = on_q;
                    rdata_d[CTRL_CNT_LSB +: IDX_W] = count_q;
                end
                REG_STATUS: begin
                    rdata_d[IDX_W-1:0] = idx_q;
                    rdata_d[STAT_RUN_BIT] = (state_q == ST_RUN);
                    rdata_d[STAT_TEXP_BIT] = texp_q;
                    rdata_d[STAT_TRUN_BIT] = trun_q;
                    rdata_d[STAT_SEL_BIT] = sel_q;
                    rdata_d[STAT_STOP_BIT] = (state_q == ST_STOP);
                end
                REG_TIMER: rdata_d[TMR_W-1:0] = tpreset_q;
                REG_PRESET0: rdata_d[PCT_W-1:0] = preset0_q;
                REG_PRESET1: rdata_d[PCT_W-1:0] = preset1_q;
                default: begin
                    for (int i = 0; i < NUM_PAIRS; i++) begin
                        if (avs_address_i ==
                            ADDR_W'(REG_PAIR_BASE + ADDR_W'(4 * i))) begin
                            rdata_d[CODE_W-1:0] = ev_q[i];
                            rdata_d[PAIR_ACT_LSB +: CODE_W] = ac_q[i];
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            on_q <= 1'b0;
            count_q <= '0;
            tpreset_q <= '0;
            preset0_q <= '0;
            preset1_q <= '0;
            ack_q <= 1'b0;
            rdata_q <= UNMAPPED_DATA;
        end else begin
            on_q <= on_d;
            count_q <= count_d;
            tpreset_q <= tpreset_d;
            preset0_q <= preset0_d;
            preset1_q <= preset1_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end
    // Event decode for the current pair only
    assign cur_ev = ev_q[idx_q];
    assign cur_ac = ac_q[idx_q];
    always_comb begin
        case (cur_ev)
            EV_FALSE: ev_hit = 1'b0;
            EV_TRUE: ev_hit = 1'b1;
            EV_ON_REF: ev_hit = at_ref;
            EV_TIMEOUT0: ev_hit = texp_q;
            default: ev_hit = 1'b0;
        endcase
    end
    // Sequencer and timer zero; a stop holds the machine until released
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        tmr_d = tmr_q;
        trun_d = trun_q;
        texp_d = texp_q;
        sel_d = sel_q;
        act_d = 1'b0;
        acode_d = acode_q;
        if (trun_q && tick_q) begin
            if (tmr_q <= TMR_W'(1)) begin
                tmr_d = '0;
                trun_d = 1'b0;
                texp_d = 1'b1;
            end else begin
                tmr_d = tmr_q - TMR_W'(1);
            end
        end
        case (state_q)
            ST_IDLE: begin
                idx_d = '0;
                if (stop_req) begin
                    state_d = ST_STOP;
                end else if (on_q && count_q != '0) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    state_d = ST_STOP;
                end else if (!on_q || count_q == '0) begin
                    state_d = ST_IDLE;
                    idx_d = '0;
                    trun_d = 1'b0;
                    texp_d = 1'b0;
                end else if (scan_q && ev_hit) begin
                    act_d = 1'b1;
                    acode_d = cur_ac;
                    case (cur_ac)
                        AC_PRESET0: sel_d = 1'b0;
                        AC_PRESET1: sel_d = 1'b1;
                        AC_TIMER0: begin
                            tmr_d = tpreset_q;
                            trun_d = 1'b1;
                            texp_d = (tpreset_q == '0);
                        end
                        default: ;
                    endcase
                    if (idx_q >= count_q - IDX_W'(1)) begin
                        idx_d = '0;
                    end else begin
                        idx_d = idx_q + IDX_W'(1);
                    end
                end
            end
            ST_STOP: begin
                idx_d = '0;
                trun_d = 1'b0;
                texp_d = 1'b0;
                if (!stop_req) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            tmr_q <= '0;
            trun_q <= 1'b0;
            texp_q <= 1'b0;
            sel_q <= 1'b0;
            act_q <= 1'b0;
            acode_q <= AC_NONE;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
            trun_q <= trun_d;
            texp_q <= texp_d;
            sel_q <= sel_d;
            act_q <= act_d;
            acode_q <= acode_d;
        end
    end
    // Stop forces zero reference so the ramp generator runs down
    always_comb begin
        ramp_down_o = (state_q == ST_STOP);
        if (state_q == ST_STOP) begin
            active_reference_o = '0;
        end else begin
            active_reference_o = sel_q ? preset1_q : preset0_q;
        end
    end
    assign current_pair_o = idx_q + IDX_W'(1);
    assign action_pulse_o = act_q;
    assign action_code_o = acode_q;
endmodule
`default_nettype wire

// ==== src/seq_pkg.sv ====
// Purpose: Shared constants for the event/action sequencer.
// Assumes: 10 MHz system clock, Avalon-MM register access.
// Notes: Register word offsets are byte addresses on a 32-bit bus.
`default_nettype none
package seq_pkg;
    localparam int MAX_PAIRS = 20;
    localparam int CODE_W = 8;
    localparam int IDX_W = 5;
    localparam int PCT_W = 7;
    localparam int TMR_W = 24;
    localparam int ADDR_W = 8;
    // Event selector codes
    localparam logic [CODE_W-1:0] EV_FALSE = 8'h00;
    localparam logic [CODE_W-1:0] EV_TRUE = 8'h01;
    localparam logic [CODE_W-1:0] EV_ON_REF = 8'h04;
    localparam logic [CODE_W-1:0] EV_TIMEOUT0 = 8'h1E;
    // Action selector codes
    localparam logic [CODE_W-1:0] AC_NONE = 8'h01;
    localparam logic [CODE_W-1:0] AC_PRESET0 = 8'h0A;
    localparam logic [CODE_W-1:0] AC_PRESET1 = 8'h0B;
    localparam logic [CODE_W-1:0] AC_TIMER0 = 8'h1D;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TIMER = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PRESET0 = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_PRESET1 = 8'h10;
    localparam logic [ADDR_W-1:0] REG_PAIR_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] REG_PAIR_END = 8'h8C;
    // Field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_CNT_LSB = 8;
    localparam int PAIR_ACT_LSB = 8;
    localparam int STAT_RUN_BIT = 8;
    localparam int STAT_TEXP_BIT = 9;
    localparam int STAT_TRUN_BIT = 10;
    localparam int STAT_SEL_BIT = 11;
    localparam int STAT_STOP_BIT = 12;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SCAN_US = 1000;
    localparam int SCAN_CYC = SCAN_US * (CLK_HZ / 1_000_000);
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
    localparam int STOP_TICKS = 1;
endpackage
`default_nettype wire
